//--- verilog/lpv_lo_path_vco_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpv_defs.svh"

module lpv_lo_path_vco_regs (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_le,
  input wire logic lo_port_select_pin,
  input wire logic [5:0] band_cal_result,
  output logic mod_bias_en,
  output logic mod_out_en,
  output lpv_pkg::lpv_lo_mode_e lo_mode,
  output logic lo_port_drive_en,
  output logic [5:0] active_band,
  output logic [5:0] vco_amplitude,
  output logic charge_pump_en,
  output logic pll_on,
  output logic internal_vco_on,
  output logic ext_vco_mode
);

  function automatic logic is_sel(input logic [23:0] w, input logic [2:0] code);
    is_sel = (w[`LPV_SEL_MSB:`LPV_SEL_LSB] == code);
  endfunction : is_sel

  logic word_valid;
  logic [23:0] word;
  lpv_pkg::lpv_regs_s r_q;
  lpv_pkg::lpv_regs_s r_d;

  lpv_serial_rx u_rx (
    .clk(clk),
    .reset_n(reset_n),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .ser_le(ser_le),
    .word_valid(word_valid),
    .word(word)
  );

  always_comb begin
    logic sel;
    logic ext_in;
    logic drv;
    logic mult;
    sel = 1'b0;
    ext_in = 1'b0;
    drv = 1'b0;
    mult = 1'b0;
    r_d = r_q;
    // Select pin comes from outside the clock domain; host keeps it driven
    r_d.sel_sync = {r_q.sel_sync[0], lo_port_select_pin};
    if (word_valid) begin
      if (is_sel(word, `LPV_SEL_LO_PATH)) begin
        r_d.lo_path = word;
      end
      if (is_sel(word, `LPV_SEL_VCO_CTRL)) begin
        r_d.vco_ctrl = word;
      end
      if (is_sel(word, `LPV_SEL_EXT_VCO)) begin
        r_d.ext_vco = word;
      end
    end
    r_d.mod_bias_en = r_q.lo_path[`LPV_MOD_BIAS_BIT];
    r_d.mod_out_en = r_q.lo_path[`LPV_MOD_BIAS_BIT] & r_q.lo_path[`LPV_MOD_OUT_BIT];
    sel = r_q.sel_sync[1];
    ext_in = r_q.lo_path[`LPV_LO_EXT_IN_BIT];
    drv = r_q.lo_path[`LPV_LO_DRIVER_BIT];
    mult = r_q.lo_path[`LPV_LO_MULT_BIT];
    if (!sel && ext_in && !drv) begin
      r_d.lo_mode = lpv_pkg::LPV_LO_INPUT;
    end else if (sel || drv) begin
      r_d.lo_mode = mult ? lpv_pkg::LPV_LO_OUT_2X : lpv_pkg::LPV_LO_OUT_1X;
    end else begin
      r_d.lo_mode = lpv_pkg::LPV_LO_DISABLED;
    end
    r_d.lo_port_drive_en = !(!sel && ext_in && !drv) && (sel || drv);
    // Band source 0 follows calibration, 1 takes the manual band
    r_d.active_band = r_q.vco_ctrl[`LPV_BAND_SRC_BIT] ?
                      r_q.vco_ctrl[`LPV_BAND_MSB:`LPV_BAND_LSB] : band_cal_result;
    r_d.vco_amplitude = r_q.vco_ctrl[`LPV_AMP_MSB:`LPV_AMP_LSB];
    r_d.pll_on = |r_q.vco_ctrl[`LPV_PLL_MSB:`LPV_PLL_LSB];
    r_d.charge_pump_en = r_q.vco_ctrl[`LPV_CP_EN_BIT];
    r_d.ext_vco_mode = r_q.ext_vco[`LPV_EXT_VCO_BIT] &&
                       (r_q.vco_ctrl[`LPV_AMP_MSB:`LPV_AMP_LSB] == 6'h00);
    r_d.internal_vco_on = !r_d.ext_vco_mode &&
                          (|r_q.vco_ctrl[`LPV_VCO_EN_MSB:`LPV_VCO_EN_LSB]);
  end

  // Derived outputs start off and settle from the defaults one cycle later
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r_q <= '0;
      r_q.lo_path <= `LPV_RST_LO_PATH;
      r_q.vco_ctrl <= `LPV_RST_VCO_CTRL;
      r_q.ext_vco <= `LPV_RST_EXT_VCO;
      r_q.lo_mode <= lpv_pkg::LPV_LO_DISABLED;
    end else begin
      r_q <= r_d;
    end
  end

  assign mod_bias_en = r_q.mod_bias_en;
  assign mod_out_en = r_q.mod_out_en;
  assign lo_mode = r_q.lo_mode;
  assign lo_port_drive_en = r_q.lo_port_drive_en;
  assign active_band = r_q.active_band;
  assign vco_amplitude = r_q.vco_amplitude;
  assign charge_pump_en = r_q.charge_pump_en;
  assign pll_on = r_q.pll_on;
  assign internal_vco_on = r_q.internal_vco_on;
  assign ext_vco_mode = r_q.ext_vco_mode;

endmodule : lpv_lo_path_vco_regs

`default_nettype wire

//--- inc/lpv_defs.svh
`ifndef LPV_DEFS_SVH
`define LPV_DEFS_SVH

// Serial word
`define LPV_WORD_W 24
`define LPV_SEL_MSB 2
`define LPV_SEL_LSB 0

// Register select codes in the three low bits of a word
`define LPV_SEL_LO_PATH 3'h5
`define LPV_SEL_VCO_CTRL 3'h6
`define LPV_SEL_EXT_VCO 3'h7

// Reset values
`define LPV_RST_LO_PATH 24'h0000d5
`define LPV_RST_VCO_CTRL 24'h1e2106
`define LPV_RST_EXT_VCO 24'h000007

// LO path and modulator control fields
`define LPV_LO_DRIVER_BIT 3
`define LPV_LO_EXT_IN_BIT 4
`define LPV_LO_MULT_BIT 5
`define LPV_MOD_BIAS_BIT 6
`define LPV_MOD_OUT_BIT 7

// VCO control and enable fields
`define LPV_BAND_LSB 3
`define LPV_BAND_MSB 8
`define LPV_BAND_SRC_BIT 9
`define LPV_AMP_LSB 10
`define LPV_AMP_MSB 15
`define LPV_PLL_LSB 17
`define LPV_PLL_MSB 20
`define LPV_CP_EN_BIT 20
`define LPV_VCO_EN_LSB 17
`define LPV_VCO_EN_MSB 19

// External VCO enable field
`define LPV_EXT_VCO_BIT 22

`endif

//--- inc/lpv_pkg.sv
package lpv_pkg;

  typedef enum logic [3:0] {
    LPV_LO_DISABLED = 4'h1,
    LPV_LO_INPUT = 4'h2,
    LPV_LO_OUT_1X = 4'h4,
    LPV_LO_OUT_2X = 4'h8
  } lpv_lo_mode_e;

  typedef struct packed {
    logic [1:0] clk_sync;
    logic [1:0] data_sync;
    logic [1:0] le_sync;
    logic clk_prev;
    logic le_prev;
    logic [23:0] shift;
    logic word_valid;
    logic [23:0] word;
  } lpv_ser_s;

  typedef struct packed {
    logic [23:0] lo_path;
    logic [23:0] vco_ctrl;
    logic [23:0] ext_vco;
    logic [1:0] sel_sync;
    logic mod_bias_en;
    logic mod_out_en;
    lpv_lo_mode_e lo_mode;
    logic lo_port_drive_en;
    logic [5:0] active_band;
    logic [5:0] vco_amplitude;
    logic charge_pump_en;
    logic pll_on;
    logic internal_vco_on;
    logic ext_vco_mode;
  } lpv_regs_s;

endpackage : lpv_pkg

//--- verilog/lpv_serial_rx.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpv_defs.svh"

module lpv_serial_rx (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_le,
  output logic word_valid,
  output logic [23:0] word
);

  lpv_pkg::lpv_ser_s s_q;
  lpv_pkg::lpv_ser_s s_d;

  // Edges are taken from the second sync stage only; the serial clock
  // must stay well below a quarter of clk for each edge to be seen.
  always_comb begin
    s_d = s_q;
    s_d.clk_sync = {s_q.clk_sync[0], ser_clk};
    s_d.data_sync = {s_q.data_sync[0], ser_data};
    s_d.le_sync = {s_q.le_sync[0], ser_le};
    s_d.clk_prev = s_q.clk_sync[1];
    s_d.le_prev = s_q.le_sync[1];
    s_d.word_valid = 1'b0;
    if (s_q.clk_sync[1] && !s_q.clk_prev && !s_q.le_sync[1]) begin
      s_d.shift = {s_q.shift[22:0], s_q.data_sync[1]};
    end
    if (s_q.le_sync[1] && !s_q.le_prev) begin
      s_d.word_valid = 1'b1;
      s_d.word = s_q.shift;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign word_valid = s_q.word_valid;
  assign word = s_q.word;

endmodule : lpv_serial_rx

`default_nettype wire

//--- bench/lpv_props.sv
`timescale 1ns/1ps
`default_nettype none
module lpv_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic lo_port_select_pin,
  input wire logic mod_bias_en,
  input wire logic mod_out_en,
  input wire lpv_pkg::lpv_lo_mode_e lo_mode,
  input wire logic lo_port_drive_en,
  input wire logic [5:0] vco_amplitude,
  input wire logic charge_pump_en,
  input wire logic pll_on,
  input wire logic internal_vco_on,
  input wire logic ext_vco_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Pin held long enough to pass the two sync stages and the output flop
  sequence s_pin_hi; lo_port_select_pin [*4]; endsequence
  property p_out; mod_out_en |-> mod_bias_en; endproperty
  a_out: assert property (p_out) else $error("output stage on, bias off");
  property p_rst; $rose(reset_n) |=> mod_bias_en && mod_out_en && vco_amplitude == 6'h08
    && charge_pump_en && pll_on && internal_vco_on && !ext_vco_mode; endproperty
  a_rst: assert property (p_rst) else $error("bad defaults");
  property p_hot; $onehot(lo_mode); endproperty
  a_hot: assert property (p_hot) else $error("lo mode not one-hot");
  property p_drv; lo_port_drive_en == (lo_mode inside {lpv_pkg::LPV_LO_OUT_1X,
    lpv_pkg::LPV_LO_OUT_2X}); endproperty
  a_drv: assert property (p_drv) else $error("drive enable off mode");
  property p_pin; s_pin_hi |-> lo_port_drive_en; endproperty
  a_pin: assert property (p_pin) else $error("pin high, port not out");
  property p_cp; charge_pump_en |-> pll_on; endproperty
  a_cp: assert property (p_cp) else $error("pump on, pll off");
  property p_ext; ext_vco_mode |-> vco_amplitude == 6'h00 && !internal_vco_on; endproperty
  a_ext: assert property (p_ext) else $error("bad external vco mode");
  property p_pll; !pll_on |-> !charge_pump_en && !internal_vco_on; endproperty
  a_pll: assert property (p_pll) else $error("pll off, parts on");
endmodule : lpv_props
bind lpv_lo_path_vco_regs lpv_props i_lpv_props (.clk, .reset_n, .lo_port_select_pin,
  .mod_bias_en, .mod_out_en, .lo_mode, .lo_port_drive_en, .vco_amplitude, .charge_pump_en,
  .pll_on, .internal_vco_on, .ext_vco_mode);
`default_nettype wire

//--- bench/lpv_host.sv
`timescale 1ns/1ps
`default_nettype none
module lpv_host (
  input wire logic clk,
  output var logic ser_clk,
  output var logic ser_data,
  output var logic ser_le
);
  initial begin
    ser_clk = 1'b0;
    ser_le = 1'b0;
    ser_data = 1'b0;
  end
  // Phases of 4 clk leave margin over the 3 clk the sampler needs
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      @(posedge clk);
      #1 ser_data = w[i];
      repeat (4) @(posedge clk);
      #1 ser_clk = 1'b1;
      repeat (4) @(posedge clk);
      #1 ser_clk = 1'b0;
    end
    repeat (4) @(posedge clk);
    #1 ser_le = 1'b1;
    ser_data = ~w[0];
    repeat (4) @(posedge clk);
    #1 ser_le = 1'b0;
    repeat (8) @(posedge clk);
    #1;
  endtask : send
endmodule : lpv_host
`default_nettype wire

//--- bench/lpv_lo_path_vco_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module lpv_lo_path_vco_regs_tb_top;
  logic clk, reset_n, pin, ser_clk, ser_data, ser_le, mbe, moe, drv, cp, pll, ivco, xvco;
  logic [5:0] band, ab, amp;
  lpv_pkg::lpv_lo_mode_e mode;
  logic [23:0] l, v, e;
  logic [31:0] seed;
  int err_total, checked;
  logic [23:0] hand [7] = '{24'h400007, 24'h000006, 24'h00001d, 24'h000015, 24'h0002ce,
    24'hfffffc, 24'h1efc06};
  wire logic [22:0] got = {mbe, moe, mode, drv, ab, amp, cp, pll, ivco, xvco};
  lpv_lo_path_vco_regs i_lpv_lo_path_vco_regs (.clk(clk), .reset_n(reset_n),
    .ser_clk(ser_clk), .ser_data(ser_data), .ser_le(ser_le), .lo_port_select_pin(pin),
    .band_cal_result(band), .mod_bias_en(mbe), .mod_out_en(moe), .lo_mode(mode),
    .lo_port_drive_en(drv), .active_band(ab), .vco_amplitude(amp), .charge_pump_en(cp),
    .pll_on(pll), .internal_vco_on(ivco), .ext_vco_mode(xvco));
  lpv_host i_lpv_host (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_le(ser_le));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic [22:0] expv(input logic [23:0] r5, r6, r7, input logic p);
    logic [3:0] m;
    logic x;
    x = r7[22] & (r6[15:10] == 6'h00);
    m = (!p & r5[4] & !r5[3]) ? 4'h2 : (!p & !r5[3]) ? 4'h1 : r5[5] ? 4'h8 : 4'h4;
    return {r5[6], r5[6] & r5[7], m, m[3] | m[2], r6[9] ? r6[8:3] : band, r6[15:10],
      r6[20], |r6[20:17], !x & |r6[19:17], x};
  endfunction : expv
  task automatic chk(input logic [22:0] ex);
    checked++;
    if (got !== ex) begin
      $display("wrong value at %0t got %h exp %h", $time, got, ex);
      err_total++;
    end
  endtask : chk
  task automatic rst();
    @(posedge clk);
    #1 reset_n = 1'b0;
    repeat (8) @(posedge clk);
    #1 reset_n = 1'b1;
    {l, v, e} = {24'h0000d5, 24'h1e2106, 24'h000007};
    repeat (4) @(posedge clk);
    #1 chk(expv(l, v, e, pin));
  endtask : rst
  task automatic step(input logic [23:0] w);
    i_lpv_host.send(w);
    case (w[2:0])
      3'h5: l = w;
      3'h6: v = w;
      3'h7: e = w;
      default: ;
    endcase
    chk(expv(l, v, e, pin));
  endtask : step
  task report_and_stop();
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  initial begin
    {reset_n, pin, band, seed, err_total, checked} = {8'h15, 32'd62, 64'd0};
    rst();
    foreach (hand[i]) step(hand[i]);
    // Pin always driven to a level, never left open
    repeat (24) begin
      seed = xs(seed);
      pin = seed[31];
      band = seed[30:25];
      step(seed[23:0]);
    end
    rst();
    report_and_stop();
  end
endmodule : lpv_lo_path_vco_regs_tb_top
`default_nettype wire
